// ---- core/lane_array.sv ----
module lane_array
    import async_ram_pkg::*;
(
    input  wire logic                                 sys_clk,
    input  wire logic                                 wr_en,
    input  wire logic [1:0]                           lane_wr,
    input  wire logic [async_ram_pkg::ADDR_W-1:0]     addr,
    input  wire logic [async_ram_pkg::DATA_W-1:0]     wr_data,
    output logic      [async_ram_pkg::DATA_W-1:0]     rd_data
);
    import async_ram_pkg::*;

    // Array is 4M words of two byte lanes
    logic [LANE_W-1:0] low_mem  [DEPTH];
    logic [LANE_W-1:0] high_mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en && lane_wr[0]) begin
            low_mem[addr] <= wr_data[LANE_W-1:0];
        end
        if (wr_en && lane_wr[1]) begin
            high_mem[addr] <= wr_data[DATA_W-1:LANE_W];
        end
        rd_data <= {high_mem[addr], low_mem[addr]};
    end
endmodule

// ---- core/psram_async_core.sv ----
// Notes on behaviour
// - Both held high 200 us before normal operation begins.
// - Power-up default is asynchronous page read and asynchronous write.
// - Raising latch pin during sleep returns straight to standby.
// - Mode bits A15/A14 both zero select asynchronous operation.
// - Clock input ignored in asynchronous mode; address-valid only gates the setting cycle.
// - Wait output stays high-impedance in asynchronous mode.
// - Array is 4M words of 16 bits, two byte lanes.
// - A0 to A4 carry the refresh field holding the sleep bits.
// - A14 and A15 select the operation mode.
// - Reserved code in the mode field falls back to its default; the refresh field is stored as written.
module psram_async_core
    import async_ram_pkg::*;
(
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic                              chip_select_n,
    input  wire logic                              config_latch_n,
    input  wire logic                              output_enable_n,
    input  wire logic                              write_enable_n,
    input  wire logic                              lower_lane_enable_n,
    input  wire logic                              upper_lane_enable_n,
    input  wire logic                              addr_valid_n,
    input  wire logic                              burst_clk,
    input  wire logic [async_ram_pkg::ADDR_W-1:0]  addr,
    input  wire logic [async_ram_pkg::DATA_W-1:0]  data_in,
    output logic      [async_ram_pkg::DATA_W-1:0]  data_out,
    output logic      [1:0]                        data_oe,
    output logic                                   wait_out,
    output logic                                   wait_oe,
    output logic                                   ready,
    output logic                                   sleeping,
    output logic      [1:0]                        op_mode,
    output logic      [4:0]                        refresh_cfg
);
    import async_ram_pkg::*;

    power_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [1:0] mode_reg, mode_next;
    logic [4:0] refresh_reg, refresh_next;
    logic [1:0] oe_reg, oe_next;
    logic       setting_program_cycle;
    logic       normal;
    logic       wr_en;
    logic       rd_en;
    logic       suspend_go;
    logic [1:0] lanes;
    logic [DATA_W-1:0] rd_data;

    // Reserved operation-mode code maps to default
    function automatic logic [1:0] legal_mode(input logic [1:0] code);
        if (code == MODE_ASYNC || code == MODE_SYNC_RW || code == MODE_SYNC_R_AW) begin
            return code;
        end
        return MODE_DEFAULT;
    endfunction

    // Selected with the latch pin high is the only state that reaches the array
    function automatic logic array_access(input logic sel_n, input logic latch_n);
        return !sel_n && latch_n;
    endfunction

    // Both pins high is what starts and holds the power-up wait
    function automatic logic power_hold(input logic sel_n, input logic latch_n);
        return sel_n && latch_n;
    endfunction

    function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] value);
        return value + CNT_W'(1);
    endfunction

    // Sleep is armed only by the enable bit set and the select bit clear
    function automatic logic sleep_armed(input logic [4:0] cfg);
        return cfg[SLEEP_EN_BIT] && !cfg[SLEEP_SEL_BIT];
    endfunction

    assign normal = (state_reg == ST_STANDBY);
    assign lanes = {~upper_lane_enable_n, ~lower_lane_enable_n};
    assign setting_program_cycle = normal && !chip_select_n && !config_latch_n
        && !addr_valid_n && !write_enable_n && output_enable_n
        && !lower_lane_enable_n && !upper_lane_enable_n;
    assign wr_en = normal && array_access(chip_select_n, config_latch_n)
        && !write_enable_n && output_enable_n;
    // read decode; both strobes low neither reads nor writes
    assign rd_en = normal && array_access(chip_select_n, config_latch_n)
        && !output_enable_n && write_enable_n;
    // latch low while deselected, only when sleep is armed
    assign suspend_go = chip_select_n && !config_latch_n && sleep_armed(refresh_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ST_RESET: begin
                cnt_next = '0;
                if (power_hold(chip_select_n, config_latch_n)) begin
                    state_next = ST_POWER_UP;
                end
            end
            ST_POWER_UP: begin
                // hold interval
                // Dropping either pin restarts the wait instead of resuming it
                if (!power_hold(chip_select_n, config_latch_n)) begin
                    cnt_next = '0;
                end else if (cnt_reg == CNT_W'(POWER_UP_CYCLES - 1)) begin
                    state_next = ST_STANDBY;
                    cnt_next = '0;
                end else begin
                    cnt_next = count_up(cnt_reg);
                end
            end
            ST_STANDBY: begin
                cnt_next = '0;
                if (suspend_go) begin
                    state_next = ST_SUSPEND;
                    cnt_next = CNT_W'(1);
                end
            end
            ST_SUSPEND: begin
                if (config_latch_n || !chip_select_n) begin
                    state_next = ST_STANDBY;
                    cnt_next = '0;
                end else if (cnt_reg == CNT_W'(SLEEP_ENTRY_CYCLES)) begin
                    state_next = ST_SLEEP;
                end else begin
                    cnt_next = count_up(cnt_reg);
                end
            end
            ST_SLEEP: begin
                cnt_next = '0;
                if (config_latch_n) begin
                    state_next = ST_STANDBY;
                end
            end
            default: begin
                state_next = ST_RESET;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_RESET;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Mode register is written only by a setting cycle
    always_comb begin
        mode_next = mode_reg;
        refresh_next = refresh_reg;
        if (setting_program_cycle) begin
            mode_next = legal_mode(addr[MODE_MSB:MODE_LSB]);
            refresh_next = addr[REFRESH_MSB:REFRESH_LSB];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_reg <= MODE_DEFAULT;
            refresh_reg <= REFRESH_DEFAULT;
        end else begin
            mode_reg <= mode_next;
            refresh_reg <= refresh_next;
        end
    end

    always_comb begin
        oe_next = 2'h0;
        if (rd_en) begin
            oe_next = lanes;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oe_reg <= 2'h0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    lane_array u_array (
        .sys_clk (sys_clk),
        .wr_en   (wr_en),
        .lane_wr (lanes),
        .addr    (addr),
        .wr_data (data_in),
        .rd_data (rd_data)
    );

    // async only; clock not used, valid strobe only gates the setting cycle
    // Registered read data follows the address by one edge
    assign data_out = rd_data;
    assign data_oe = oe_reg;
    // wait never driven while asynchronous; sync modes are out of scope
    assign wait_out = 1'b0;
    assign wait_oe = 1'b0;
    assign ready = normal;
    assign sleeping = (state_reg == ST_SLEEP);
    assign op_mode = mode_reg;
    assign refresh_cfg = refresh_reg;
endmodule

// ---- include/async_ram_pkg.sv ----
package async_ram_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int DEPTH = 4194304;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int POWER_UP_US = 200;
    localparam int SLEEP_ENTRY_NS = 500;
    localparam int POWER_UP_CYCLES = (POWER_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Strictly longer than the suspend period
    localparam int SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_NS / CLK_PERIOD_NS + 1;
    localparam int CNT_W = 13;
    // Mode register fields
    localparam int REFRESH_LSB = 0;
    localparam int REFRESH_MSB = 4;
    localparam int SLEEP_EN_BIT = 4;
    localparam int SLEEP_SEL_BIT = 3;
    localparam int MODE_LSB = 14;
    localparam int MODE_MSB = 15;
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC_RW = 2'h2;
    localparam logic [1:0] MODE_SYNC_R_AW = 2'h1;
    localparam logic [1:0] MODE_DEFAULT = MODE_ASYNC;
    localparam logic [4:0] REFRESH_DEFAULT = 5'h00;

    typedef enum logic [4:0] {
        ST_RESET     = 5'h01,
        ST_POWER_UP  = 5'h02,
        ST_STANDBY   = 5'h04,
        ST_SUSPEND   = 5'h08,
        ST_SLEEP     = 5'h10
    } power_state_t;
endpackage

// ---- test/host_data_model.sv ----
module host_data_model (
    input wire logic        sys_clk,
    input wire logic        write_enable_n,
    input wire logic [15:0] wr_data,
    output logic [15:0]     data_in,
    output logic            burst_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] hold_reg = 16'h0;
    logic        bclk_reg = 1'b0;
    always_ff @(posedge sys_clk) begin
        hold_reg <= write_enable_n ? ~hold_reg : wr_data;
        bclk_reg <= ~bclk_reg;
    end
    assign data_in = write_enable_n ? hold_reg : wr_data;
    assign burst_clk = bclk_reg;
endmodule

// ---- test/psram_async_assertions.sv ----
module psram_async_chk
    import async_ram_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              chip_select_n,
    input wire logic              config_latch_n,
    input wire logic              output_enable_n,
    input wire logic              write_enable_n,
    input wire logic              lower_lane_enable_n,
    input wire logic              upper_lane_enable_n,
    input wire logic              addr_valid_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0]        data_oe,
    input wire logic              wait_oe,
    input wire logic              ready,
    input wire logic              sleeping,
    input wire logic [1:0]        op_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rd = ready & ~chip_select_n & config_latch_n & ~output_enable_n & write_enable_n;
    wire setc = ready & ~chip_select_n & ~config_latch_n & ~addr_valid_n & ~write_enable_n
        & ~lower_lane_enable_n & ~upper_lane_enable_n & output_enable_n;
    property p_wait; wait_oe == 1'b0; endproperty
    a_wait: assert property (p_wait) else $error("wait driven");
    property p_rst; @(posedge sys_clk) disable iff (1'b0) rst |=> !ready && !sleeping; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_read; rd |=> data_oe == ~{$past(upper_lane_enable_n), $past(lower_lane_enable_n)}; endproperty
    a_read: assert property (p_read) else $error("read lanes wrong");
    property p_desel; chip_select_n |=> data_oe == 2'h0; endproperty
    a_desel: assert property (p_desel) else $error("lanes driven deselected");
    property p_both; !output_enable_n && !write_enable_n |=> data_oe == 2'h0; endproperty
    a_both: assert property (p_both) else $error("lanes driven oe and we low");
    property p_wake; sleeping && config_latch_n |=> ready; endproperty
    a_wake: assert property (p_wake) else $error("no direct wake");
    property p_res; setc && addr[15:14] == 2'h3 |=> op_mode == MODE_DEFAULT; endproperty
    a_res: assert property (p_res) else $error("reserved mode kept");
    property p_mode; setc && addr[15:14] != 2'h3 |=> op_mode == $past(addr[15:14]); endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");
    property p_slp; $rose(sleeping) |-> !$past(config_latch_n, 11) && !$past(config_latch_n); endproperty
    a_slp: assert property (p_slp) else $error("early sleep");
endmodule
bind psram_async_core psram_async_chk i_chk (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .chip_select_n       (chip_select_n),
    .config_latch_n      (config_latch_n),
    .output_enable_n     (output_enable_n),
    .write_enable_n      (write_enable_n),
    .lower_lane_enable_n (lower_lane_enable_n),
    .upper_lane_enable_n (upper_lane_enable_n),
    .addr_valid_n        (addr_valid_n),
    .addr                (addr),
    .data_oe             (data_oe),
    .wait_oe             (wait_oe),
    .ready               (ready),
    .sleeping            (sleeping),
    .op_mode             (op_mode)
);

// ---- test/tb_psram_async_mode_power_control.sv ----
module tb_psram_async_mode_power_control;
    import async_ram_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst = 1;
    logic [6:0] p = 7'h7f;
    logic [21:0] a = 22'h0;
    logic [15:0] d = 16'h0, din, dout;
    logic [1:0] doe, om;
    logic [4:0] rc;
    logic wo, woe, rdy, slp, bclk;
    int n_mismatch = 0, comparisons = 0;
    logic [62:0] rows [10] = '{
        {7'h31, 22'h5, 16'h1234, 2'h0, 16'h0}, {7'h29, 22'h5, 16'h0, 2'h3, 16'h1234},
        {7'h33, 22'h5, 16'hff56, 2'h0, 16'h0}, {7'h2b, 22'h5, 16'h0, 2'h1, 16'h0056},
        {7'h35, 22'h5, 16'h78aa, 2'h0, 16'h0}, {7'h2d, 22'h5, 16'h0, 2'h2, 16'h7800},
        {7'h21, 22'h5, 16'hdead, 2'h0, 16'h0}, {7'h69, 22'h5, 16'h0, 2'h0, 16'h0},
        {7'h31, 22'h3fffff, 16'hbeef, 2'h0, 16'h0}, {7'h28, 22'h3fffff, 16'h0, 2'h3, 16'hbeef}};
    initial forever #25 sys_clk = ~sys_clk;
    host_data_model i_host (.sys_clk(sys_clk), .write_enable_n(p[3]), .wr_data(d),
        .data_in(din), .burst_clk(bclk));
    psram_async_core i_dut (.sys_clk(sys_clk), .rst(rst), .chip_select_n(p[6]),
        .config_latch_n(p[5]), .output_enable_n(p[4]), .write_enable_n(p[3]),
        .lower_lane_enable_n(p[2]), .upper_lane_enable_n(p[1]), .addr_valid_n(p[0]),
        .burst_clk(bclk), .addr(a), .data_in(din), .data_out(dout), .data_oe(doe),
        .wait_out(wo), .wait_oe(woe), .ready(rdy), .sleeping(slp), .op_mode(om),
        .refresh_cfg(rc));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task op(input logic [6:0] pv, input logic [21:0] av, input logic [15:0] dv);
        @(posedge sys_clk);
        p <= pv;
        a <= av;
        d <= dv;
        @(posedge sys_clk);
        #1;
    endtask
    task close_out;
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 0;
        #1;
        chk({rdy, slp, om, rc}, 16'h0);
        op(7'h29, 22'h5, 16'h0);
        chk(doe, 2'h0);
        op(7'h5f, 22'h0, 16'h0);
        op(7'h7f, 22'h0, 16'h0);
        repeat (POWER_UP_CYCLES - 2) @(posedge sys_clk);
        #1;
        chk(rdy, 1'b0);
        @(posedge sys_clk);
        #1;
        chk({rdy, om, wo, woe}, 5'h10);
        op(7'h10, 22'h00c00b, 16'h0);
        op(7'h7f, 22'h0, 16'h0);
        chk({om, rc}, 7'h0b);
        op(7'h5f, 22'h0, 16'h0);
        repeat (12) @(posedge sys_clk);
        #1;
        chk({rdy, slp}, 2'h2);
        op(7'h10, 22'h008010, 16'h0);
        chk({om, rc}, 7'h50);
        op(7'h10, 22'h000010, 16'h0);
        op(7'h7f, 22'h0, 16'h0);
        chk({om, rc}, 7'h10);
        for (int i = 0; i < 10; i++) begin
            op(rows[i][62:56], rows[i][55:34], rows[i][33:18]);
            chk(doe, rows[i][17:16]);
            chk(dout & {{8{rows[i][17]}}, {8{rows[i][16]}}}, rows[i][15:0]);
        end
        // Refused double strobe left the word intact
        op(7'h29, 22'h5, 16'h0);
        chk(dout, 16'h7856);
        // Suspend cut short returns to standby
        op(7'h5f, 22'h0, 16'h0);
        op(7'h7f, 22'h0, 16'h0);
        chk({rdy, slp}, 2'h2);
        op(7'h5f, 22'h0, 16'h0);
        repeat (10) @(posedge sys_clk);
        #1;
        chk(slp, 1'b0);
        @(posedge sys_clk);
        #1;
        chk({rdy, slp}, 2'h1);
        op(7'h7f, 22'h0, 16'h0);
        chk({rdy, slp}, 2'h2);
        op(7'h10, 22'h008010, 16'h0);
        chk({om, rc}, 7'h50);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk({rdy, slp, om, rc}, 16'h0);
        close_out();
    end
endmodule
